//--- core/idle_countdown.sv
// millisecond idle countdown: reloads on each serial byte, fires once at zero
// assumes tick is a one-cycle pulse once per millisecond
`timescale 1ns/1ps
module idle_countdown (
	input  wire logic       clk,
	input  wire logic       rst_n,
	input  wire logic       tick,
	input  wire logic       reload,
	input  wire logic [7:0] reload_value,
	output logic            expired
);

	logic [7:0] count_reg;
	logic [7:0] count_next;
	logic       armed_reg;
	logic       armed_next;
	logic       expired_next;

	always_comb begin
		count_next   = count_reg;
		armed_next   = armed_reg;
		expired_next = 1'b0;
		if (reload) begin
			count_next = reload_value;
			armed_next = (reload_value != 8'h00);
		end else if (armed_reg && tick) begin
			count_next = count_reg - 8'h01;
			if (count_reg == 8'h01) begin
				armed_next   = 1'b0;
				expired_next = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count_reg <= 8'h00;
			armed_reg <= 1'b0;
			expired   <= 1'b0;
		end else begin
			count_reg <= count_next;
			armed_reg <= armed_next;
			expired   <= expired_next;
		end
	end

endmodule // idle_countdown

//--- core/radio_cfg.svh
// register offsets, field positions, factory defaults and timing counts
// for the radio module configuration bank; definitions only
`ifndef RADIO_CFG_SVH
`define RADIO_CFG_SVH

`define OFS_STORED_TX_CHANNEL     8'h00
`define OFS_STORED_RX_CHANNEL     8'h01
`define OFS_STORED_POWER_SELECT   8'h02
`define OFS_STORED_BAUD_SELECT    8'h03
`define OFS_STORED_NETWORK_ROLE   8'h04
`define OFS_STORED_SEND_TIMEOUT   8'h05
`define OFS_STORED_UNIT_SIZE      8'h09
`define OFS_LIVE_TX_CHANNEL       8'h4b
`define OFS_LIVE_RX_CHANNEL       8'h4c
`define OFS_LIVE_POWER_SELECT     8'h4d
`define OFS_LIVE_BAUD_SELECT      8'h4e
`define OFS_LIVE_NETWORK_ROLE     8'h4f
`define OFS_LIVE_SEND_TIMEOUT     8'h50
`define OFS_LIVE_UNIT_SIZE        8'h54

`define CHAN_MSB                  6
`define WB_CHAN_MSB               5
`define SEL_MSB                   2

`define DEF_TX_CHANNEL            8'h00
`define DEF_RX_CHANNEL            8'h00
`define DEF_POWER_SELECT          8'h03
`define DEF_BAUD_SELECT           8'h00
`define DEF_NETWORK_ROLE          8'h01
`define DEF_SEND_TIMEOUT          8'h10
`define DEF_UNIT_SIZE             8'h40
`define UNIT_SIZE_MIN             8'h01
`define UNIT_SIZE_MAX             8'h90
`define ROLE_SLAVE                8'h00

`define WB_CHAN_LAST              7'h1f
`define NB_CHAN_FIRST             7'h01
`define NB_CHAN_LAST              7'h53

`define CLK_PERIOD_NS             100
`define MS_TICK_NS                1000000
`define MS_TICK_CYCLES            (`MS_TICK_NS / `CLK_PERIOD_NS)

`endif

//--- core/radio_module_config_regs.sv
// configuration register bank of a serial-to-radio module
// assumes the serial command parser delivers register requests as strobes,
// and that the packet engine reports each received serial byte and buffer fill
`timescale 1ns/1ps
`include "radio_cfg.svh"
module radio_module_config_regs #(
	parameter int  MS_TICK_CYCLES  = `MS_TICK_CYCLES,
	parameter bit  NO_NB_CHANNEL0  = 1'b1,
	parameter bit  REGIONAL        = 1'b0
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              cmd_sel_n,
	input  radio_pkg::reg_req_s    reg_req,
	input  wire logic              rx_byte_stb,
	input  wire logic [7:0]        buf_fill,
	input  radio_pkg::peer_s       peer,
	output logic [7:0]             reg_rdata,
	output logic                   reg_rvalid,
	output logic                   transparent,
	output logic [6:0]             tx_channel,
	output logic [6:0]             rx_channel,
	output radio_pkg::band_e       band,
	output radio_pkg::level_e      power_level,
	output logic [16:0]            baud_bps,
	output logic                   slave_mode,
	output logic                   send_start,
	output logic                   peer_accept
);

	typedef enum logic [1:0] {
		ST_RESET,
		ST_BOOT,
		ST_RUN
	} phase_e;

	phase_e             phase_reg;
	phase_e             phase_next;
	radio_pkg::cfg_s    stored_reg;
	radio_pkg::cfg_s    stored_next;
	radio_pkg::cfg_s    live_reg;
	radio_pkg::cfg_s    live_next;
	radio_pkg::cfg_s    factory;
	logic [7:0]         rdata_next;
	logic               rvalid_next;
	logic [13:0]        ms_cnt_reg;
	logic [13:0]        ms_cnt_next;
	logic               ms_tick_reg;
	logic               ms_tick_next;
	logic               idle_expired;
	logic               fill_hit;
	logic               send_next;
	logic               wide;
	logic [6:0]         tx_chan_next;
	logic [6:0]         rx_chan_next;
	logic [16:0]        baud_next;
	logic               accept_next;
	radio_pkg::level_e  level_next;
	logic               cmd_mode;

	assign factory = '{tx_channel:   `DEF_TX_CHANNEL,
	                   rx_channel:   `DEF_RX_CHANNEL,
	                   power_select: `DEF_POWER_SELECT,
	                   baud_select:  `DEF_BAUD_SELECT,
	                   network_role: `DEF_NETWORK_ROLE,
	                   send_timeout: `DEF_SEND_TIMEOUT,
	                   unit_size:    `DEF_UNIT_SIZE};

	// band membership of the power field; 001..100 are the wideband codes
	function automatic logic is_wide(input logic [7:0] sel);
		logic [2:0] code;
		code = sel[`SEL_MSB:0];
		return (code >= 3'h1) && (code <= 3'h4);
	endfunction

	// effective channel after masking, range limit, zero remap and aliasing
	function automatic logic [6:0] map_channel(input logic [7:0] raw,
	                                           input logic wb);
		logic [6:0] ch;
		ch = raw[`CHAN_MSB:0];
		if (wb) begin
			ch = {1'b0, raw[`WB_CHAN_MSB:0]};
			if (ch > `WB_CHAN_LAST)
				ch = `WB_CHAN_LAST;
			if (REGIONAL && ch >= 7'h0c && ch <= 7'h11)
				ch = 7'h12;
			else if (REGIONAL && ch >= 7'h05 && ch <= 7'h0b)
				ch = 7'h04;
		end else begin
			if (ch > `NB_CHAN_LAST)
				ch = `NB_CHAN_LAST;
			if (ch == 7'h00 && (NO_NB_CHANNEL0 || REGIONAL))
				ch = `NB_CHAN_FIRST;
			if (REGIONAL && ch >= 7'h0e && ch <= 7'h1d)
				ch = 7'h0d;
			else if (REGIONAL && ch >= 7'h1e && ch <= 7'h2c)
				ch = 7'h2d;
		end
		return ch;
	endfunction

	// ---- boot phase and register file ----
	assign cmd_mode = !cmd_sel_n && (phase_reg == ST_RUN);

	always_comb begin
		phase_next  = phase_reg;
		stored_next = stored_reg;
		live_next   = live_reg;
		rdata_next  = reg_rdata;
		rvalid_next = 1'b0;
		case (phase_reg)
			ST_RESET: begin
				phase_next = ST_BOOT;
				if (!cmd_sel_n)
					stored_next = factory;
			end
			ST_BOOT: begin
				live_next  = stored_reg;
				phase_next = ST_RUN;
			end
			ST_RUN: begin
				if (cmd_mode && reg_req.wr) begin
					case (reg_req.addr)
						`OFS_STORED_TX_CHANNEL:   stored_next.tx_channel   = reg_req.wdata;
						`OFS_STORED_RX_CHANNEL:   stored_next.rx_channel   = reg_req.wdata;
						`OFS_STORED_POWER_SELECT: stored_next.power_select = reg_req.wdata;
						`OFS_STORED_BAUD_SELECT:  stored_next.baud_select  = reg_req.wdata;
						`OFS_STORED_NETWORK_ROLE: stored_next.network_role = reg_req.wdata;
						`OFS_STORED_SEND_TIMEOUT: stored_next.send_timeout = reg_req.wdata;
						`OFS_STORED_UNIT_SIZE:    stored_next.unit_size    = reg_req.wdata;
						`OFS_LIVE_TX_CHANNEL:     live_next.tx_channel     = reg_req.wdata;
						`OFS_LIVE_RX_CHANNEL:     live_next.rx_channel     = reg_req.wdata;
						`OFS_LIVE_POWER_SELECT:   live_next.power_select   = reg_req.wdata;
						`OFS_LIVE_BAUD_SELECT:    live_next.baud_select    = reg_req.wdata;
						`OFS_LIVE_NETWORK_ROLE:   live_next.network_role   = reg_req.wdata;
						`OFS_LIVE_SEND_TIMEOUT:   live_next.send_timeout   = reg_req.wdata;
						`OFS_LIVE_UNIT_SIZE:      live_next.unit_size      = reg_req.wdata;
						default: ;
					endcase
				end
				if (cmd_mode && reg_req.rd) begin
					rvalid_next = 1'b1;
					case (reg_req.addr)
						`OFS_STORED_TX_CHANNEL:   rdata_next = stored_reg.tx_channel;
						`OFS_STORED_RX_CHANNEL:   rdata_next = stored_reg.rx_channel;
						`OFS_STORED_POWER_SELECT: rdata_next = stored_reg.power_select;
						`OFS_STORED_BAUD_SELECT:  rdata_next = stored_reg.baud_select;
						`OFS_STORED_NETWORK_ROLE: rdata_next = stored_reg.network_role;
						`OFS_STORED_SEND_TIMEOUT: rdata_next = stored_reg.send_timeout;
						`OFS_STORED_UNIT_SIZE:    rdata_next = stored_reg.unit_size;
						`OFS_LIVE_TX_CHANNEL:     rdata_next = live_reg.tx_channel;
						`OFS_LIVE_RX_CHANNEL:     rdata_next = live_reg.rx_channel;
						`OFS_LIVE_POWER_SELECT:   rdata_next = live_reg.power_select;
						`OFS_LIVE_BAUD_SELECT:    rdata_next = live_reg.baud_select;
						`OFS_LIVE_NETWORK_ROLE:   rdata_next = live_reg.network_role;
						`OFS_LIVE_SEND_TIMEOUT:   rdata_next = live_reg.send_timeout;
						`OFS_LIVE_UNIT_SIZE:      rdata_next = live_reg.unit_size;
						default:                  rdata_next = 8'h00;
					endcase
				end
			end
			default: phase_next = ST_RESET;
		endcase
	end

	// stored copy models non-volatile cells: rst_n leaves it alone, but a reset with cmd_sel_n low reloads the factory values
	always_ff @(posedge clk) begin
		stored_reg <= stored_next;
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			phase_reg  <= ST_RESET;
			live_reg   <= factory;
			reg_rdata  <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			phase_reg  <= phase_next;
			live_reg   <= live_next;
			reg_rdata  <= rdata_next;
			reg_rvalid <= rvalid_next;
		end
	end

	// ---- decoded settings, all but transparent taken from the live copy ----
	always_comb begin
		wide         = is_wide(live_reg.power_select);
		tx_chan_next = map_channel(live_reg.tx_channel, wide);
		rx_chan_next = map_channel(live_reg.rx_channel, wide);
		case (live_reg.power_select[`SEL_MSB:0])
			3'h0, 3'h4: level_next = radio_pkg::LEVEL_LOW;
			3'h1, 3'h5: level_next = radio_pkg::LEVEL_MID_LOW;
			3'h2, 3'h6: level_next = radio_pkg::LEVEL_MID_HIGH;
			default:    level_next = radio_pkg::LEVEL_HIGH;
		endcase
		case (live_reg.baud_select[`SEL_MSB:0])
			3'h0:    baud_next = 17'h0960;
			3'h1:    baud_next = 17'h2580;
			3'h2:    baud_next = 17'h4b00;
			3'h3:    baud_next = 17'h9600;
			3'h4:    baud_next = 17'he100;
			3'h5:    baud_next = 17'h1_c200;
			3'h6:    baud_next = 17'h28a0;
			default: baud_next = 17'h7a12;
		endcase
		// same family only; two slaves never pair
		accept_next = peer.valid && (peer.wideband == wide)
		              && !(peer.slave && (live_reg.network_role == `ROLE_SLAVE));
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_channel  <= 7'h00;
			rx_channel  <= 7'h00;
			band        <= radio_pkg::BAND_NARROW;
			power_level <= radio_pkg::LEVEL_LOW;
			baud_bps    <= 17'h0960;
			slave_mode  <= 1'b0;
			peer_accept <= 1'b0;
			transparent <= 1'b0;
		end else begin
			tx_channel  <= tx_chan_next;
			rx_channel  <= rx_chan_next;
			band        <= wide ? radio_pkg::BAND_WIDE : radio_pkg::BAND_NARROW;
			power_level <= level_next;
			baud_bps    <= baud_next;
			slave_mode  <= (live_reg.network_role == `ROLE_SLAVE);
			peer_accept <= accept_next;
			transparent <= cmd_sel_n && (phase_reg == ST_RUN);
		end
	end

	// ---- millisecond tick and transmit trigger ----
	always_comb begin
		ms_tick_next = 1'b0;
		ms_cnt_next  = ms_cnt_reg + 14'h0001;
		if (ms_cnt_reg == 14'(MS_TICK_CYCLES - 1)) begin
			ms_cnt_next  = 14'h0000;
			ms_tick_next = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ms_cnt_reg  <= 14'h0000;
			ms_tick_reg <= 1'b0;
		end else begin
			ms_cnt_reg  <= ms_cnt_next;
			ms_tick_reg <= ms_tick_next;
		end
	end

	idle_countdown u_idle (
		.clk          (clk),
		.rst_n        (rst_n),
		.tick         (ms_tick_reg),
		.reload       (rx_byte_stb && transparent),
		.reload_value (live_reg.send_timeout),
		.expired      (idle_expired)
	);

	// out-of-range unit sizes are clamped so a full buffer always sends
	always_comb begin
		if (live_reg.unit_size < `UNIT_SIZE_MIN)
			fill_hit = buf_fill >= `UNIT_SIZE_MIN;
		else if (live_reg.unit_size > `UNIT_SIZE_MAX)
			fill_hit = buf_fill >= `UNIT_SIZE_MAX;
		else
			fill_hit = buf_fill >= live_reg.unit_size;
		send_next = transparent && (idle_expired || fill_hit);
	end

	always_ff @(posedge clk) begin
		if (!rst_n)
			send_start <= 1'b0;
		else
			send_start <= send_next;
	end

endmodule // radio_module_config_regs

//--- core/radio_pkg.sv
// types shared by the configuration bank and its verification models
// assumes radio_cfg.svh supplies all numeric constants
package radio_pkg;

	typedef enum logic {
		BAND_NARROW,
		BAND_WIDE
	} band_e;

	typedef enum logic [1:0] {
		LEVEL_LOW,
		LEVEL_MID_LOW,
		LEVEL_MID_HIGH,
		LEVEL_HIGH
	} level_e;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic [7:0] tx_channel;
		logic [7:0] rx_channel;
		logic [7:0] power_select;
		logic [7:0] baud_select;
		logic [7:0] network_role;
		logic [7:0] send_timeout;
		logic [7:0] unit_size;
	} cfg_s;

	typedef struct packed {
		logic wideband;
		logic slave;
		logic valid;
	} peer_s;

endpackage

//--- verification/host_model.sv
// host microcontroller side: command select, register requests, serial bytes
// assumes the bench waits out boot before the first request
`timescale 1ns/1ps
module host_model (
	input wire logic            clk,
	output logic                cmd_sel_n,
	output radio_pkg::reg_req_s reg_req,
	output logic                rx_byte_stb
);
	logic [7:0] exp_q[$];
	initial begin
		cmd_sel_n = 1'b0;
		reg_req = '0;
		rx_byte_stb = 1'b0;
	end
	task automatic step();
		@(posedge clk);
		#1;
	endtask
	// requests go out whatever command select is; the bank ignores them while it is high
	task automatic put(input logic w, input logic [7:0] a, input logic [7:0] d);
		step();
		reg_req = {w, !w, a, d};
		step();
		reg_req = '0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		put(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		put(1'b0, a, 8'h00);
	endtask
	task automatic mode(input logic v);
		step();
		cmd_sel_n = v;
	endtask
	task automatic byte_in();
		step();
		rx_byte_stb = 1'b1;
		step();
		rx_byte_stb = 1'b0;
	endtask
endmodule // host_model

//--- verification/radio_cfg_monitor.sv
// port checker for the radio configuration bank
// bound to every radio_module_config_regs instance, one clock domain
`timescale 1ns/1ps
module radio_cfg_monitor #(
	parameter bit REGIONAL = 1'b0
) (
	input wire logic           clk,
	input wire logic           rst_n,
	input wire logic           cmd_sel_n,
	input radio_pkg::reg_req_s reg_req,
	input wire logic [7:0]     buf_fill,
	input radio_pkg::peer_s    peer,
	input wire logic           reg_rvalid,
	input wire logic           transparent,
	input wire logic [6:0]     tx_channel,
	input wire logic [6:0]     rx_channel,
	input radio_pkg::band_e    band,
	input wire logic [16:0]    baud_bps,
	input wire logic           slave_mode,
	input wire logic           send_start,
	input wire logic           peer_accept
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// decoded outputs lag reset release by a few edges
	logic [2:0] run_reg;
	logic [2:0] run_next;
	logic       up;
	always_comb begin
		run_next = (run_reg == 3'h7) ? run_reg : run_reg + 3'h1;
		if (!rst_n)
			run_next = 3'h0;
	end
	always_ff @(posedge clk) begin
		run_reg <= run_next;
	end
	assign up = (run_reg == 3'h7);
	a_baud_reset: assert property ($rose(rst_n) |-> baud_bps == 17'h0960)
		else $error("baud rate not 2400 after reset");
	a_baud_legal: assert property (up |-> baud_bps inside {17'h0960, 17'h2580,
		17'h4b00, 17'h9600, 17'he100, 17'h1_c200, 17'h28a0, 17'h7a12})
		else $error("baud rate outside the table");
	a_wide_chan: assert property (up && band == radio_pkg::BAND_WIDE |->
		tx_channel <= 7'h1f && rx_channel <= 7'h1f)
		else $error("wideband channel above 31");
	a_narrow_chan: assert property (up && band == radio_pkg::BAND_NARROW |->
		tx_channel inside {[7'h01:7'h53]} && rx_channel inside {[7'h01:7'h53]})
		else $error("narrowband channel outside 1 to 83");
	a_region_alias: assert property (up && REGIONAL |-> !((band == radio_pkg::BAND_WIDE) ?
		tx_channel inside {[7'h05:7'h11]} : tx_channel inside {[7'h0e:7'h2c]}))
		else $error("aliased channel selected");
	a_fill_send: assert property (transparent && buf_fill >= 8'h90 |=> send_start)
		else $error("full buffer did not start sending");
	// band and role outputs lag the live copy by one edge, as peer_accept lags peer
	a_band_deaf: assert property ($past(peer.valid) && $past(peer.wideband) != band |->
		!peer_accept)
		else $error("frame of other band accepted");
	a_slave_pair: assert property ($past(peer.valid) && $past(peer.slave) && slave_mode |->
		!peer_accept)
		else $error("slave accepted a slave");
	a_peer_hear: assert property ($past(rst_n) && $past(peer.valid) &&
		$past(peer.wideband) == band && !($past(peer.slave) && slave_mode) |-> peer_accept)
		else $error("compatible frame refused");
	a_read_cause: assert property (reg_rvalid |-> $past(reg_req.rd) && !$past(cmd_sel_n))
		else $error("read answer without command mode read");
	c_send: cover property (send_start);
	c_slave: cover property (slave_mode);
	c_accept: cover property (peer_accept);
endmodule // radio_cfg_monitor

bind radio_module_config_regs radio_cfg_monitor #(.REGIONAL(REGIONAL)) mon (
	.clk(clk), .rst_n(rst_n), .cmd_sel_n(cmd_sel_n), .reg_req(reg_req),
	.buf_fill(buf_fill), .peer(peer), .reg_rvalid(reg_rvalid),
	.transparent(transparent), .tx_channel(tx_channel), .rx_channel(rx_channel),
	.band(band), .baud_bps(baud_bps), .slave_mode(slave_mode),
	.send_start(send_start), .peer_accept(peer_accept));

//--- verification/tb.sv
// self-checking bench for the radio configuration bank
// host_model drives the command port; the bench drives fill and peer inputs
`timescale 1ns/1ps
module tb;
	logic                clk = 1'b0;
	logic                rst_n = 1'b0;
	logic [7:0]          buf_fill = 8'h00;
	radio_pkg::peer_s    peer = '0;
	logic                cmd_sel_n, rx_byte_stb, reg_rvalid, transparent;
	logic                slave_mode, send_start, peer_accept, w, s;
	radio_pkg::reg_req_s reg_req;
	logic [7:0]          reg_rdata;
	logic [6:0]          tx_channel, rx_channel;
	radio_pkg::band_e    band;
	radio_pkg::level_e   power_level;
	logic [16:0]         baud_bps;
	logic [31:0]         seed = 32'h0000_8ea9;
	logic [31:0]         r;
	logic [16:0]         bauds [8] = '{17'h0960, 17'h2580, 17'h4b00, 17'h9600,
		17'he100, 17'h1_c200, 17'h28a0, 17'h7a12};
	logic [7:0]          defs [6] = '{8'h00, 8'h00, 8'h03, 8'h00, 8'h01, 8'h10};
	int                  bad_count = 0;
	int                  cmp_count = 0;
	int                  n;
	always #50 clk = ~clk;
	host_model host (.clk(clk), .cmd_sel_n(cmd_sel_n), .reg_req(reg_req),
		.rx_byte_stb(rx_byte_stb));
	radio_module_config_regs #(.MS_TICK_CYCLES(10),
		.REGIONAL(1'b1)) dut (.clk(clk), .rst_n(rst_n), .cmd_sel_n(cmd_sel_n),
		.reg_req(reg_req), .rx_byte_stb(rx_byte_stb), .buf_fill(buf_fill),
		.peer(peer), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.transparent(transparent), .tx_channel(tx_channel), .rx_channel(rx_channel),
		.band(band), .power_level(power_level), .baud_bps(baud_bps),
		.slave_mode(slave_mode), .send_start(send_start), .peer_accept(peer_accept));
	task automatic check(input string nm, input logic [16:0] e, input logic [16:0] v);
		cmp_count++;
		if (v !== e) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, v);
		end
	endtask
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(negedge clk) begin
		if (reg_rvalid === 1'b1)
			check("read data", 17'(host.exp_q.pop_front()), 17'(reg_rdata));
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [6:0] eff(input logic [7:0] v, input logic wb);
		logic [6:0] c;
		c = wb ? {1'b0, v[5:0]} : v[6:0];
		if (wb && c > 7'h1f) c = 7'h1f;
		if (!wb && c == 7'h00) c = 7'h01;
		if (!wb && c > 7'h53) c = 7'h53;
		if (wb && c inside {[7'h0c:7'h11]}) c = 7'h12;
		if (wb && c inside {[7'h05:7'h0b]}) c = 7'h04;
		if (!wb && c inside {[7'h0e:7'h1d]}) c = 7'h0d;
		if (!wb && c inside {[7'h1e:7'h2c]}) c = 7'h2d;
		return c;
	endfunction
	// stored settings survive a reset only with command select high
	task automatic do_reset(input logic cmd);
		host.mode(cmd);
		rst_n = 1'b0;
		repeat (5) host.step();
		rst_n = 1'b1;
		repeat (4) host.step();
		host.mode(1'b0);
	endtask
	task automatic watch(input int k, output logic sent);
		sent = 1'b0;
		repeat (k) begin
			host.step();
			sent |= send_start;
		end
	endtask
	initial begin
		do_reset(1'b0);
		check("reset baud", 17'h0960, baud_bps);
		check("command mode", 17'h0000, 17'(transparent));
		for (int i = 0; i < 6; i++) begin
			host.rd(8'(i), defs[i]);
			host.rd(8'(8'h4b + i), defs[i]);
		end
		host.rd(8'h30, 8'h00);
		$display("defaults done");
		for (int c = 0; c < 8; c++) begin
			host.wr(8'h4d, 8'(c));
			host.wr(8'h4e, 8'(c));
			repeat (2) host.step();
			check("band", 17'(c inside {[1:4]}), 17'(band));
			check("level", 17'(c % 4), 17'(power_level));
			check("baud", bauds[c], baud_bps);
		end
		$display("decode done");
		for (int i = 0; i < 16; i++) begin
			r = rnd();
			w = r[2:0] inside {[3'h1:3'h4]};
			host.wr(8'h4d, {5'h00, r[2:0]});
			host.wr(8'h4b, {1'b0, r[14:8]});
			host.wr(8'h4c, {1'b0, r[22:16]});
			host.wr(8'h4f, {r[24], 7'h00});
			peer = radio_pkg::peer_s'(r[27:25]);
			repeat (2) host.step();
			check("tx channel", 17'(eff({1'b0, r[14:8]}, w)), 17'(tx_channel));
			check("rx channel", 17'(eff({1'b0, r[22:16]}, w)), 17'(rx_channel));
			check("slave", 17'(!r[24]), 17'(slave_mode));
			check("accept", 17'(r[25] && r[27] == w && !(r[26] && !r[24])), 17'(peer_accept));
			host.rd(8'h4c, {1'b0, r[22:16]});
		end
		peer = '{wideband: w, slave: 1'b0, valid: 1'b1};
		repeat (2) host.step();
		check("same family", 17'h0001, 17'(peer_accept));
		peer = '0;
		$display("channels done");
		host.wr(8'h03, 8'h05);
		host.wr(8'h04, 8'h00);
		do_reset(1'b1);
		check("kept baud", 17'h1_c200, baud_bps);
		check("kept slave", 17'h0001, 17'(slave_mode));
		do_reset(1'b0);
		check("restored baud", 17'h0960, baud_bps);
		host.rd(8'h03, 8'h00);
		$display("restore done");
		// 5 ms stays above one character time at 2400 bits per second
		host.wr(8'h50, 8'h05);
		host.mode(1'b1);
		host.byte_in();
		check("transparent", 17'h0001, 17'(transparent));
		n = 0;
		while (send_start !== 1'b1 && n < 80) begin
			host.step();
			n++;
		end
		check("idle send time", 17'h0001, 17'(n inside {[42:51]}));
		if (n == 80)
			stop_test();
		host.mode(1'b0);
		host.wr(8'h50, 8'h00);
		host.mode(1'b1);
		host.byte_in();
		host.wr(8'h4e, 8'h07);
		watch(60, s);
		check("no idle send", 17'h0000, 17'(s));
		r = rnd();
		buf_fill = {2'b00, r[5:0]};
		watch(5, s);
		check("short fill", 17'h0000, 17'(s));
		buf_fill = 8'h90 | r[15:8];
		watch(3, s);
		check("full fill", 17'h0001, 17'(s));
		buf_fill = 8'h00;
		host.mode(1'b0);
		host.rd(8'h4e, 8'h00);
		host.step();
		$display("trigger done");
		stop_test();
	end
endmodule // tb
